// ### logic/rpt_pkg.sv
package rpt_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MON_CTRL  = 10'h2f1;
  localparam logic [9:0] IDX_PER_CTRL  = 10'h2f2;
  localparam logic [9:0] IDX_OSC_TRIM  = 10'h2f3;
  localparam logic [9:0] IDX_RATE_HI   = 10'h2f4;
  localparam logic [9:0] IDX_RATE_LO   = 10'h2f5;
  localparam logic [9:0] IDX_TEMP_TRIM = 10'h2f7;

  // monitor control / status fields
  localparam int MON_LV_FLAG   = 0;
  localparam int MON_LV_IE     = 1;
  localparam int MON_LV_STATUS = 2;
  localparam int MON_OT_FLAG   = 3;
  localparam int MON_OT_IE     = 4;
  localparam int MON_OT_STATUS = 5;

  // periodic timer control fields
  localparam int PER_FLAG   = 0;
  localparam int PER_IE     = 1;
  localparam int PER_FE     = 2;
  localparam int PER_PIN_EN = 3;
  localparam int PER_WSEL   = 4;
  localparam int PER_CLKSEL = 7;

  // trim fields
  localparam int OSC_TRIM_LSB   = 2;
  localparam int OSC_TRIM_W     = 6;
  localparam int TEMP_OFS_EN    = 7;
  localparam int TEMP_THR_W     = 4;

  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_RATE  = 16'h0000;
  localparam logic [16:0] RST_COUNT = 17'h00000;

  // comparator vector layout for the synchronisers
  localparam int CMP_SUP_BELOW = 0;
  localparam int CMP_SUP_ABOVE = 1;
  localparam int CMP_TMP_ABOVE = 2;
  localparam int CMP_TMP_BELOW = 3;
  localparam int CMP_POR_LOW   = 4;
  localparam int CMP_DROP_LOW  = 5;
  localparam int CMP_DROP_HIGH = 8;
  localparam int CMP_W         = 11;
  localparam int NUM_DROP      = 3;
endpackage : rpt_pkg

// ### logic/rpt_regulator_ctrl.sv
`timescale 1ns/1ps
module rpt_regulator_ctrl #(
  parameter logic [5:0] OSC_TRIM_RESET = 6'h00  // factory preset, arbitrary default
) (
  input  wire logic                         clk_i,                  // bus clock, 40 MHz
  input  wire logic                         rst_i,                  // synchronous reset, high
  input  wire logic                         wb_cyc_i,               // wishbone cycle
  input  wire logic                         wb_stb_i,               // wishbone strobe
  input  wire logic                         wb_we_i,                // wishbone write
  input  wire logic [11:0]                  wb_adr_i,               // wishbone byte address
  input  wire logic [3:0]                   wb_sel_i,               // wishbone byte select
  input  wire logic [31:0]                  wb_dat_i,               // wishbone write data
  output logic      [31:0]                  wb_dat_o,               // wishbone read data
  output logic                              wb_ack_o,               // wishbone acknowledge
  input  wire logic                         full_performance_mode_i, // regulator in full performance mode
  input  wire logic                         supply_below_assert_i,  // analog supply under assert level
  input  wire logic                         supply_above_deassert_i, // analog supply over deassert level
  input  wire logic                         temp_above_assert_i,    // die temp over assert level
  input  wire logic                         temp_below_deassert_i,  // die temp under deassert level
  input  wire logic                         core_supply_low_i,      // core supply under power-on level
  input  wire logic [rpt_pkg::NUM_DROP-1:0] drop_below_i,           // core/io/nvm supplies under assert
  input  wire logic [rpt_pkg::NUM_DROP-1:0] drop_above_i,           // core/io/nvm supplies over deassert
  input  wire logic                         rc_tick_i,              // one pulse per RC oscillator tick
  input  wire logic                         bus_clock_on_i,         // bus clock running
  output logic                              low_voltage_irq_o,      // low-voltage interrupt request
  output logic                              overtemp_irq_o,         // overtemp interrupt request
  output logic                              periodic_irq_o,         // periodic interrupt request
  output logic                              periodic_pin_o,         // external periodic waveform
  output logic                              por_reset_o,            // power-on reset request
  output logic                              startup_start_o,        // pulse at power-on reset release
  output logic                              supply_drop_reset_o,    // supply-drop reset request
  output logic                              temp_offset_enable_o,   // temperature sense offset on
  output logic [rpt_pkg::TEMP_THR_W-1:0]    temp_threshold_trim_o,  // threshold trim steps
  output logic [rpt_pkg::OSC_TRIM_W-1:0]    oscillator_trim_o       // RC oscillator trim
);
  import rpt_pkg::*;

  // ----------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------
  logic [CMP_W-1:0] cmp_raw;
  wire  [CMP_W-1:0] cmp_s;

  assign cmp_raw = {drop_above_i, drop_below_i, core_supply_low_i, temp_below_deassert_i,
                    temp_above_assert_i, supply_above_deassert_i, supply_below_assert_i};

  genvar gi;
  generate
    for (gi = 0; gi < CMP_W; gi++) begin : g_sync
      logic stage1;
      logic stage2;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= cmp_raw[gi];
          stage2 <= stage1;
        end
      end
      assign cmp_s[gi] = stage2;
    end
  endgenerate

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic [7:0]  mon_ctrl;
  logic [7:0]  per_ctrl;

  // register fields as separate flops, packed for readback
  logic        lv_flag;
  logic        lv_ie;
  logic        ot_flag;
  logic        ot_ie;
  logic        per_flag;
  logic        per_ie;
  logic        per_fe;
  logic        per_pin_en;
  logic        per_wsel;
  logic        per_clk_sel;
  logic [7:0]  temp_trim;
  logic [5:0]  osc_trim;
  logic [15:0] rate;
  logic [7:0]  rd_byte;
  logic        lv_status;
  logic        ot_status;

  wire [9:0] widx    = wb_adr_i[11:2];
  wire       wb_req  = wb_cyc_i & wb_stb_i;
  wire       wr      = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire [7:0] wdat    = wb_dat_i[7:0];
  wire       hit_mon = (widx == IDX_MON_CTRL);
  wire       hit_per = (widx == IDX_PER_CTRL);
  wire       hit_osc = (widx == IDX_OSC_TRIM);
  wire       hit_rhi = (widx == IDX_RATE_HI);
  wire       hit_rlo = (widx == IDX_RATE_LO);
  wire       hit_tmp = (widx == IDX_TEMP_TRIM);

  wire       fe      = per_ctrl[PER_FE];
  wire       clk_sel = per_ctrl[PER_CLKSEL];

  wire [7:0] mon_view = {2'b00, ot_status, mon_ctrl[MON_OT_IE], mon_ctrl[MON_OT_FLAG],
                         lv_status, mon_ctrl[MON_LV_IE], mon_ctrl[MON_LV_FLAG]};

  // unmapped addresses read zero
  assign rd_byte = hit_mon ? mon_view :
                   hit_per ? per_ctrl :
                   hit_osc ? {osc_trim, 2'b00} :
                   hit_rhi ? rate[15:8] :
                   hit_rlo ? rate[7:0] :
                   hit_tmp ? temp_trim : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // locked fields only follow writes while disabled
  wire cfg_open = ~fe;
  wire lv_clr   = wr & hit_mon & wdat[MON_LV_FLAG];
  wire ot_clr   = wr & hit_mon & wdat[MON_OT_FLAG];
  wire per_clr  = wr & hit_per & wdat[PER_FLAG];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lv_ie       <= 1'b0;
      ot_ie       <= 1'b0;
      per_ie      <= 1'b0;
      per_fe      <= 1'b0;
      per_pin_en  <= 1'b0;
      per_wsel    <= 1'b0;
      per_clk_sel <= 1'b0;
      osc_trim  <= OSC_TRIM_RESET;
      temp_trim <= RST_BYTE;
      rate      <= RST_RATE;
    end else begin
      if (wr && hit_mon) begin
        lv_ie <= wdat[MON_LV_IE];
        ot_ie <= wdat[MON_OT_IE];
      end
      if (wr && hit_per) begin
        per_ie     <= wdat[PER_IE];
        per_fe     <= wdat[PER_FE];
        per_pin_en <= wdat[PER_PIN_EN];
        per_wsel   <= wdat[PER_WSEL];
        if (cfg_open) begin
          per_clk_sel <= wdat[PER_CLKSEL];
        end
      end
      if (wr && hit_osc) begin
        osc_trim <= wdat[7:2];
      end
      // offset enable and trim bits, reserved bits stay zero
      if (wr && hit_tmp) begin
        temp_trim <= {wdat[TEMP_OFS_EN], 3'b000, wdat[TEMP_THR_W-1:0]};
      end
      if (wr && hit_rhi && cfg_open) begin
        rate[15:8] <= wdat;
      end
      if (wr && hit_rlo && cfg_open) begin
        rate[7:0] <= wdat;
      end
    end
  end

  // status bits are inserted by the read view, not stored here
  always_comb begin
    mon_ctrl              = 8'h00;
    mon_ctrl[MON_LV_FLAG] = lv_flag;
    mon_ctrl[MON_LV_IE]   = lv_ie;
    mon_ctrl[MON_OT_FLAG] = ot_flag;
    mon_ctrl[MON_OT_IE]   = ot_ie;
  end

  always_comb begin
    per_ctrl             = 8'h00;
    per_ctrl[PER_FLAG]   = per_flag;
    per_ctrl[PER_IE]     = per_ie;
    per_ctrl[PER_FE]     = per_fe;
    per_ctrl[PER_PIN_EN] = per_pin_en;
    per_ctrl[PER_WSEL]   = per_wsel;
    per_ctrl[PER_CLKSEL] = per_clk_sel;
  end

  // field is a plain binary step count for the analog trim
  assign temp_offset_enable_o  = temp_trim[TEMP_OFS_EN];
  assign temp_threshold_trim_o = temp_trim[TEMP_THR_W-1:0];
  assign oscillator_trim_o     = osc_trim;

  // ----------------------------------------------------------------
  // low-voltage and overtemp monitors
  // ----------------------------------------------------------------
  wire perf_mode = full_performance_mode_i;

  // hysteresis from two comparators, held between levels
  // status frozen outside full performance mode
  wire next_lv_status = ~perf_mode ? lv_status :
                        cmp_s[CMP_SUP_BELOW] ? 1'b1 :
                        cmp_s[CMP_SUP_ABOVE] ? 1'b0 : lv_status;
  // overtemp frozen outside full performance mode
  wire next_ot_status = ~perf_mode ? ot_status :
                        cmp_s[CMP_TMP_ABOVE] ? 1'b1 :
                        cmp_s[CMP_TMP_BELOW] ? 1'b0 : ot_status;
  wire lv_change = next_lv_status ^ lv_status;
  wire ot_change = next_ot_status ^ ot_status;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lv_status <= 1'b0;
      ot_status <= 1'b0;
      lv_flag   <= 1'b0;
      ot_flag   <= 1'b0;
    end else begin
      lv_status <= next_lv_status;
      ot_status <= next_ot_status;
      // any change sets, set wins over clear
      // leaving full performance never touches the flag; returning sets it if the comparators moved meanwhile
      lv_flag <= lv_change | (lv_flag & ~lv_clr);
      // overtemp flag on each status change
      ot_flag <= ot_change | (ot_flag & ~ot_clr);
    end
  end

  assign low_voltage_irq_o = mon_ctrl[MON_LV_FLAG] & mon_ctrl[MON_LV_IE];
  assign overtemp_irq_o    = mon_ctrl[MON_OT_FLAG] & mon_ctrl[MON_OT_IE];

  // ----------------------------------------------------------------
  // reset requests
  // ----------------------------------------------------------------
  logic por_prev;
  logic drop_state;

  // any supply low asserts, all high releases, full performance only
  wire any_low  = |cmp_s[CMP_DROP_LOW +: NUM_DROP];
  wire all_high = &cmp_s[CMP_DROP_HIGH +: NUM_DROP];
  wire next_drop = ~perf_mode ? 1'b0 :
                   any_low ? 1'b1 :
                   all_high ? 1'b0 : drop_state;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_prev        <= 1'b0;
      drop_state      <= 1'b0;
      startup_start_o <= 1'b0;
    end else begin
      por_prev        <= cmp_s[CMP_POR_LOW];
      drop_state      <= next_drop;
      // release of power-on reset launches start-up
      startup_start_o <= por_prev & ~cmp_s[CMP_POR_LOW];
    end
  end

  // power-on reset held in every mode, without waiting for a clock; supply-drop reset registered, full performance only
  assign por_reset_o         = core_supply_low_i;
  assign supply_drop_reset_o = drop_state;

  // ----------------------------------------------------------------
  // periodic wakeup timer
  // ----------------------------------------------------------------
  logic [16:0] count;
  logic        pin_toggle;
  logic        pin_pulse;

  // tick source, stopped bus clock freezes the count when the bus clock is selected
  wire         per_adv  = fe & (clk_sel ? bus_clock_on_i : rc_tick_i);
  // last count is two times rate plus one
  wire [16:0]  per_last = {rate, 1'b1};
  wire         per_end  = per_adv & (count == per_last);
  wire [16:0]  next_count = ~fe     ? RST_COUNT :
                            per_end ? RST_COUNT :
                            per_adv ? 17'(count + 17'h00001) : count;
  wire         pin_on   = fe & per_ctrl[PER_PIN_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count            <= RST_COUNT;
      pin_toggle       <= 1'b0;
      pin_pulse        <= 1'b0;
      periodic_pin_o   <= 1'b0;
      per_flag         <= 1'b0;
    end else begin
      // count from enable; first period starts at the first tick
      count <= next_count;
      // flag at period end, counter restarts
      per_flag <= ~per_clr & (per_end | per_flag);
      // toggle per period end, pulse lasts one tick
      pin_toggle <= fe & (pin_toggle ^ per_end);
      pin_pulse  <= fe & (per_end | (pin_pulse & ~per_adv));
      periodic_pin_o <= pin_on & (per_ctrl[PER_WSEL] ? pin_toggle : pin_pulse);
    end
  end

  assign periodic_irq_o = per_ctrl[PER_FLAG] & per_ctrl[PER_IE];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  lv_flag_set_a: assert property ($changed(lv_status) |-> mon_ctrl[MON_LV_FLAG])
    else $error("low-voltage flag missed a status change");
  lv_mode_hold_a: assert property (!perf_mode |=> $stable(lv_status))
    else $error("low-voltage status moved outside full performance mode");
  lv_hyst_a: assert property (perf_mode && cmp_s[CMP_SUP_BELOW] |=> lv_status)
    else $error("low-voltage status not set below assert level");
  ot_flag_set_a: assert property ($changed(ot_status) |-> mon_ctrl[MON_OT_FLAG])
    else $error("overtemp flag missed a status change");
  ot_mode_hold_a: assert property (!perf_mode |=> $stable(ot_status))
    else $error("overtemp status moved outside full performance mode");
  lv_flag_keep_a: assert property (mon_ctrl[MON_LV_FLAG] && !lv_clr |=> mon_ctrl[MON_LV_FLAG])
    else $error("low-voltage flag lost without a clear");
  ot_flag_keep_a: assert property (mon_ctrl[MON_OT_FLAG] && !ot_clr |=> mon_ctrl[MON_OT_FLAG])
    else $error("overtemp flag lost without a clear");
  drop_mode_a: assert property (!perf_mode |=> !supply_drop_reset_o)
    else $error("supply-drop reset outside full performance mode");
  rate_lock_a: assert property (fe |=> $stable(rate) && $stable(clk_sel))
    else $error("rate or clock select changed while enabled");
  count_freeze_a: assert property (fe && clk_sel && !bus_clock_on_i |=> $stable(count))
    else $error("count moved with bus clock stopped");
  period_wrap_a: assert property (per_end && !per_clr |=> per_ctrl[PER_FLAG] && count == RST_COUNT)
    else $error("period end did not set flag and restart");
  flag_clear_a: assert property (per_clr |=> !per_ctrl[PER_FLAG])
    else $error("periodic flag survived a clear");
  pin_quiet_a: assert property (!pin_on |=> !periodic_pin_o)
    else $error("pin active while disabled");
  startup_a: assert property ($fell(cmp_s[CMP_POR_LOW]) |=> startup_start_o)
    else $error("start-up pulse missing after power-on release");

  per_flag_c: cover property (per_end ##1 per_ctrl[PER_FLAG]);
  lv_flag_c: cover property ($rose(mon_ctrl[MON_LV_FLAG]));
  pin_clock_c: cover property (pin_on && per_ctrl[PER_WSEL] && $rose(periodic_pin_o));
  rate_write_c: cover property (wr && hit_rlo && cfg_open);
  ot_flag_c: cover property ($rose(mon_ctrl[MON_OT_FLAG]));

endmodule : rpt_regulator_ctrl

// ### verif/rpt_wb_master.sv
`timescale 1ns/1ps
module rpt_wb_master (
  input  wire logic        clk_i, // bus clock
  output logic             cyc_o, // wishbone cycle
  output logic             stb_o, // wishbone strobe
  output logic             we_o,  // write
  output logic [11:0]      adr_o, // byte address
  output logic [31:0]      dat_o, // write data
  input  wire logic [31:0] dat_i, // read data
  input  wire logic        ack_i  // acknowledge
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 12'h000;
    dat_o = 32'h00000000;
  end

  // ----
  // one classic cycle; released lines show the inverse of the last value
  // ----
  task xfer(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    dat_o <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= ~w;
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
  endtask : xfer
endmodule : rpt_wb_master

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  import rpt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, lv_irq, ot_irq, per_irq, pin, por, start, drop, ofs;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  thr;
  logic [5:0]  osc;
  logic [7:0]  v;
  logic        perf = 1'b0, sb = 1'b0, sa = 1'b1, ta = 1'b0, tl = 1'b1, core_low = 1'b0, rc = 1'b0, bus_on = 1'b1;
  logic [2:0]  dbl = 3'h0, dab = 3'h7;
  logic [9:0]  idx_tab [7] = '{IDX_MON_CTRL, IDX_PER_CTRL, IDX_OSC_TRIM, IDX_RATE_HI, IDX_RATE_LO, 10'h2f6, IDX_TEMP_TRIM};
  int          fails = 0, cmp_count = 0, seed = 58, rc_cnt = 0, n;

  always #12.5 clk_i = ~clk_i;
  // rc oscillator tick every five bus cycles
  always @(posedge clk_i) begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    rc     <= (rc_cnt == 4);
  end

  rpt_wb_master i_bus (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat),
    .dat_i(rdat), .ack_i(ack));
  rpt_regulator_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .full_performance_mode_i(perf), .supply_below_assert_i(sb), .supply_above_deassert_i(sa),
    .temp_above_assert_i(ta), .temp_below_deassert_i(tl), .core_supply_low_i(core_low),
    .drop_below_i(dbl), .drop_above_i(dab), .rc_tick_i(rc), .bus_clock_on_i(bus_on),
    .low_voltage_irq_o(lv_irq), .overtemp_irq_o(ot_irq), .periodic_irq_o(per_irq), .periodic_pin_o(pin),
    .por_reset_o(por), .startup_start_o(start), .supply_drop_reset_o(drop), .temp_offset_enable_o(ofs),
    .temp_threshold_trim_o(thr), .oscillator_trim_o(osc));

  // ----
  // helpers
  // ----
  function int period(input logic [7:0] r, input int tick);
    return 2 * (int'(r) + 1) * tick;
  endfunction : period
  function logic irq_of(input int b);
    return (b == 0) ? lv_irq : ot_irq;
  endfunction : irq_of
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [9:0] idx, input logic [7:0] d);
    i_bus.xfer(1'b1, idx, d, q);
  endtask : wr
  task rd(input logic [9:0] idx, input logic [7:0] e);
    i_bus.xfer(1'b0, idx, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask : rd
  task end_sim;
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task cmp(input int b, input logic on);
    if (b == 0) begin
      sb <= on;
      sa <= ~on;
    end else begin
      ta <= on;
      tl <= ~on;
    end
  endtask : cmp
  task mon(input int b);
    logic [7:0] f;
    f = 8'h01 << b;
    cmp(b, 1'b1);
    wr(IDX_MON_CTRL, f << 1);
    repeat (5) @(posedge clk_i);
    rd(IDX_MON_CTRL, f * 8'h07);
    chk(irq_of(b), 1'b1);
    perf <= 1'b0;
    cmp(b, 1'b0);
    repeat (5) @(posedge clk_i);
    rd(IDX_MON_CTRL, f * 8'h07);
    chk(irq_of(b), 1'b1);
    wr(IDX_MON_CTRL, f * 8'h03);
    rd(IDX_MON_CTRL, f * 8'h06);
    chk(irq_of(b), 1'b0);
    perf <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(IDX_MON_CTRL, f * 8'h03);
    wr(IDX_MON_CTRL, f);
    rd(IDX_MON_CTRL, 8'h00);
  endtask : mon
  task runs(input int stall, output int hi, output int lo);
    hi = 0;
    lo = 0;
    n = 0;
    while (pin !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (stall > 0) begin
      bus_on <= 1'b0;
      repeat (stall) @(posedge clk_i);
      bus_on <= 1'b1;
      hi = stall;
    end
    while (pin === 1'b1 && hi < 3000) begin
      @(posedge clk_i);
      hi++;
    end
    while (pin === 1'b0 && lo < 3000) begin
      @(posedge clk_i);
      lo++;
    end
  endtask : runs
  task timer(input logic bus, input logic [7:0] r, input logic wsel, input int stall, input int tick);
    int hi, lo;
    logic [7:0] c;
    c = {bus, 2'b00, wsel, 4'b1010};
    // disable, reconfigure, then enable
    wr(IDX_PER_CTRL, c);
    wr(IDX_RATE_HI, 8'h00);
    wr(IDX_RATE_LO, r);
    wr(IDX_PER_CTRL, c | 8'h04);
    wr(IDX_RATE_LO, r + 8'h01);
    wr(IDX_PER_CTRL, (c ^ 8'h80) | 8'h04);
    i_bus.xfer(1'b0, IDX_PER_CTRL, 8'h00, q);
    chk(q[7:0] & 8'hfe, c | 8'h04);
    rd(IDX_RATE_LO, r);
    runs(stall, hi, lo);
    if (wsel) begin
      chk(hi, period(r, tick) + stall);
      chk(lo, period(r, tick));
    end else begin
      chk(hi, 1);
      chk(hi + lo, period(r, tick));
    end
    chk(per_irq, 1'b1);
    wr(IDX_PER_CTRL, c);
    rd(IDX_PER_CTRL, c | 8'h01);
    wr(IDX_PER_CTRL, c | 8'h01);
    rd(IDX_PER_CTRL, c);
    chk(per_irq, 1'b0);
  endtask : timer

  // ----
  // main sequence
  // ----
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (idx_tab[i]) rd(idx_tab[i], 8'h00);
    wr(10'h2f6, 8'hff);
    rd(10'h2f6, 8'h00);
    repeat (4) begin
      v = $random(seed);
      wr(IDX_TEMP_TRIM, v);
      rd(IDX_TEMP_TRIM, v & 8'h8f);
      chk(ofs, v[7]);
      chk(thr, v[3:0]);
      wr(IDX_OSC_TRIM, v);
      rd(IDX_OSC_TRIM, v & 8'hfc);
      chk(osc, v[7:2]);
    end
    perf <= 1'b1;
    mon(MON_LV_FLAG);
    mon(MON_OT_FLAG);
    core_low <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(por, 1'b1);
    core_low <= 1'b0;
    n = 0;
    while (start !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    chk(start, 1'b1);
    chk(por, 1'b0);
    dbl <= 3'h1 << (v % 3);
    dab <= ~(3'h1 << (v % 3));
    repeat (6) @(posedge clk_i);
    chk(drop, 1'b1);
    dbl <= 3'h0;
    dab <= 3'h3;
    repeat (6) @(posedge clk_i);
    chk(drop, 1'b1);
    dab <= 3'h7;
    repeat (6) @(posedge clk_i);
    chk(drop, 1'b0);
    dbl <= 3'h4;
    dab <= 3'h3;
    repeat (6) @(posedge clk_i);
    perf <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(drop, 1'b0);
    perf <= 1'b1;
    dbl <= 3'h0;
    dab <= 3'h7;
    timer(1'b1, 8'h00, 1'b1, 0, 1);
    // nonzero rate, so the stall lands inside a pin phase and not on a period end
    v = ($random(seed) & 8'h07) | 8'h01;
    timer(1'b1, v, 1'b1, 7, 1);
    timer(1'b1, v + 8'h02, 1'b0, 0, 1);
    timer(1'b0, v, 1'b1, 0, 5);
    end_sim();
  end

  initial begin
    #(25 * 40000);
    fails++;
    end_sim();
  end
endmodule : tb
